// ---- core/dcfs_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the fault signalling block
`ifndef DCFS_REGS_SVH
`define DCFS_REGS_SVH

// Register byte offsets
`define DCFS_OFF_DEVICE_CONFIG 8'h00
`define DCFS_OFF_CHAIN_CONTROL 8'h04
`define DCFS_OFF_FAULT_MASK 8'h08
`define DCFS_OFF_FAULT_RESET 8'h0c
`define DCFS_OFF_FAULT_SUMMARY 8'h10
`define DCFS_OFF_FAULT_FLAGS 8'h14

// device_config fields
`define DCFS_CFG_ALERT_EN 0
`define DCFS_CFG_EMBED_EN 1
`define DCFS_CFG_HEARTBEAT_TX_ENABLE 2
`define DCFS_CFG_FT_EN 3
`define DCFS_CFG_RST 4'h0

// chain_control fields
`define DCFS_CTL_DIR 0
`define DCFS_CTL_SLEEP 1
`define DCFS_CTL_BASE 2
`define DCFS_CTL_RST 3'h0

// Fault group positions in mask, reset, flag and summary
`define DCFS_GRP_PWR 0
`define DCFS_GRP_SYS 1
`define DCFS_GRP_OVUV 2
`define DCFS_GRP_OTUT 3
`define DCFS_GRP_COMM 4
`define DCFS_GRP_OTP 5
`define DCFS_GRP_COMP 6
`define DCFS_GRP_PROT 7
// Communication detail flags
`define DCFS_CHAIN_SEEN 8
`define DCFS_HB_FAULT 9
`define DCFS_TONE_FAULT 10
`define DCFS_MASK_RST 11'h000

// Response frame byte positions carrying fault status
`define DCFS_BYTE_DEVADDR 3'h1
`define DCFS_BYTE_REGLO 3'h3

// Timing
`define DCFS_CLK_MHZ 40
`define DCFS_COUPLET_HALF_NS 500
`define DCFS_COUPLET_HALF_CYC ((`DCFS_COUPLET_HALF_NS * `DCFS_CLK_MHZ + 999) / 1000)
`define DCFS_BURST_GAP_NS 2000
`define DCFS_BURST_GAP_CYC ((`DCFS_BURST_GAP_NS * `DCFS_CLK_MHZ + 999) / 1000)
`define DCFS_BURST_PERIOD_US 1000
`define DCFS_BURST_CYC (`DCFS_BURST_PERIOD_US * `DCFS_CLK_MHZ)
`define DCFS_HB_MISS_BURSTS 3
`define DCFS_HB_MISS_CYC (`DCFS_HB_MISS_BURSTS * `DCFS_BURST_CYC)

// Tone couplet counts and receive thresholds
`define DCFS_HB_COUPLETS 8
`define DCFS_FT_COUPLETS 16
`define DCFS_HB_DETECT 4
`define DCFS_FT_DETECT 12

`endif

// ---- core/dcfs_pkg.sv ----
// Types shared by the fault signalling block
`default_nettype none
package dcfs_pkg;

   typedef enum logic [1:0] {TX_IDLE, TX_NEG, TX_GAP} dcfs_tx_state_type;

   typedef enum logic {RX_IDLE, RX_BURST} dcfs_rx_state_type;

endpackage

`default_nettype wire

// ---- core/dcfs_tone_tx.sv ----
// Periodic heartbeat and fault tone transmitter
`timescale 1ns/1ps
`default_nettype none
`include "dcfs_regs.svh"

module dcfs_tone_tx #(
   parameter int unsigned BURST_CYCLES = `DCFS_BURST_CYC
)(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Control
   input wire logic sleep_mode,
   input wire logic hb_enable,
   input wire logic ft_enable,
   input wire logic fault_state,
   // Tone output
   output logic couplet_neg
);

   dcfs_pkg::dcfs_tx_state_type state_q;
   logic [19:0] period_q;
   logic [4:0] left_q;
   logic [5:0] half_q;
   logic burst_start;

   assign burst_start = sleep_mode && (period_q == 20'(BURST_CYCLES - 1));

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || !sleep_mode || burst_start)
         period_q <= 20'h0_0000;
      else
         period_q <= period_q + 20'h0_0001;
   end

   // Tone kind is chosen once per burst so a burst never changes shape midway
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || !sleep_mode)
      begin
         state_q <= dcfs_pkg::TX_IDLE;
         left_q <= 5'h00;
         half_q <= 6'h00;
      end
      else
      begin
         unique case (state_q)
            dcfs_pkg::TX_IDLE:
            begin
               if (burst_start && fault_state && ft_enable)
               begin
                  state_q <= dcfs_pkg::TX_NEG;
                  left_q <= 5'(`DCFS_FT_COUPLETS);
                  half_q <= 6'h00;
               end
               else if (burst_start && !fault_state && hb_enable)
               begin
                  state_q <= dcfs_pkg::TX_NEG;
                  left_q <= 5'(`DCFS_HB_COUPLETS);
                  half_q <= 6'h00;
               end
            end
            dcfs_pkg::TX_NEG:
            begin
               if (half_q == 6'(`DCFS_COUPLET_HALF_CYC - 1))
               begin
                  state_q <= dcfs_pkg::TX_GAP;
                  half_q <= 6'h00;
               end
               else
                  half_q <= half_q + 6'h01;
            end
            dcfs_pkg::TX_GAP:
            begin
               if (half_q == 6'(`DCFS_COUPLET_HALF_CYC - 1))
               begin
                  half_q <= 6'h00;
                  left_q <= left_q - 5'h01;
                  state_q <= (left_q == 5'h01) ? dcfs_pkg::TX_IDLE : dcfs_pkg::TX_NEG;
               end
               else
                  half_q <= half_q + 6'h01;
            end
            default:
               state_q <= dcfs_pkg::TX_IDLE;
         endcase
      end
   end

   // Only negative-polarity halves are driven
   assign couplet_neg = (state_q == dcfs_pkg::TX_NEG);

endmodule

`default_nettype wire

// ---- core/dcfs_core.sv ----
// Daisy-chain fault signalling: fault flags, embedded status, alert pin and sleep tones
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dcfs_regs.svh"

module dcfs_core #(
   parameter int unsigned BURST_CYCLES = `DCFS_BURST_CYC,
   parameter int unsigned HB_MISS_CYCLES = `DCFS_HB_MISS_CYC
)(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Fault detector conditions, one per group
   input wire logic [7:0] fault_cond,
   input wire logic ovuv_prot_en,
   input wire logic otut_prot_en,
   // Response frame from the chain, bit 8 is the embedded status bit
   input wire logic rx_valid,
   input wire logic rx_first,
   input wire logic [8:0] rx_word,
   // Response frame forwarded on
   output logic tx_valid,
   output logic [8:0] tx_word,
   // Tones
   input wire logic tone_rx_neg,
   output logic couplet_neg_up,
   output logic couplet_neg_down,
   // Alert pin
   output logic fault_alert_n
);

   logic [3:0] device_config_q;
   logic [2:0] chain_control_q;
   logic [10:0] mask_q;
   logic [10:0] flag_q;
   logic [10:0] cond;
   logic [10:0] rst_req;
   logic [7:0] summary;
   logic [7:0] gate;
   logic sleep_m;
   logic fault_state;
   logic wr_en;
   logic addr_hit;
   logic [31:0] rd_d;

   assign sleep_m = chain_control_q[`DCFS_CTL_SLEEP];

   // APB: zero wait states, read data captured in the setup cycle
   assign wr_en = psel && penable && pwrite;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;

   always_comb
   begin
      addr_hit = 1'b1;
      rd_d = 32'h0000_0000;
      unique case (paddr)
         `DCFS_OFF_DEVICE_CONFIG: rd_d = {28'h000_0000, device_config_q};
         `DCFS_OFF_CHAIN_CONTROL: rd_d = {29'h0000_0000, chain_control_q};
         `DCFS_OFF_FAULT_MASK: rd_d = {21'h00_0000, mask_q};
         `DCFS_OFF_FAULT_RESET: rd_d = 32'h0000_0000;
         `DCFS_OFF_FAULT_SUMMARY: rd_d = {24'h00_0000, summary};
         `DCFS_OFF_FAULT_FLAGS: rd_d = {21'h00_0000, flag_q};
         default: addr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_d;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         device_config_q <= `DCFS_CFG_RST;
         chain_control_q <= `DCFS_CTL_RST;
         mask_q <= `DCFS_MASK_RST;
      end
      else if (wr_en)
      begin
         if (paddr == `DCFS_OFF_DEVICE_CONFIG)
            device_config_q <= pwdata[3:0];
         if (paddr == `DCFS_OFF_CHAIN_CONTROL)
            chain_control_q <= pwdata[2:0];
         if (paddr == `DCFS_OFF_FAULT_MASK)
            mask_q <= pwdata[10:0];
      end
   end

   assign rst_req = (wr_en && paddr == `DCFS_OFF_FAULT_RESET) ? pwdata[10:0] : 11'h000;

   // Detectors that stay alive in sleep; the rest only run when active
   always_comb
   begin
      gate = 8'hff;
      if (sleep_m)
      begin
         gate = 8'h00;
         gate[`DCFS_GRP_PWR] = 1'b1;
         gate[`DCFS_GRP_SYS] = 1'b1;
         gate[`DCFS_GRP_OTP] = 1'b1;
         gate[`DCFS_GRP_OVUV] = ovuv_prot_en;
         gate[`DCFS_GRP_OTUT] = otut_prot_en;
      end
   end

   // Embedded status path
   logic [2:0] idx_q;
   logic [2:0] cur_idx;
   logic [1:0] votes_q;
   logic embed_slot;
   logic vote_ev;
   logic chain_alert_q;

   assign cur_idx = rx_first ? 3'h0 : idx_q;
   assign embed_slot = device_config_q[`DCFS_CFG_EMBED_EN] && !sleep_m
                       && cur_idx >= `DCFS_BYTE_DEVADDR && cur_idx <= `DCFS_BYTE_REGLO;
   assign vote_ev = rx_valid && embed_slot && cur_idx == `DCFS_BYTE_REGLO
                    && (2'(votes_q[0]) + 2'(votes_q[1]) + 2'(rx_word[8])) >= 2'h2;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         idx_q <= 3'h0;
         votes_q <= 2'h0;
      end
      else if (rx_valid)
      begin
         idx_q <= (cur_idx == 3'h7) ? cur_idx : cur_idx + 3'h1;
         if (embed_slot && cur_idx == `DCFS_BYTE_DEVADDR)
            votes_q[0] <= rx_word[8];
         if (embed_slot && cur_idx == `DCFS_BYTE_DEVADDR + 3'h1)
            votes_q[1] <= rx_word[8];
      end
   end

   // Forwarded bytes pass one cycle late; status slots get this device's fault ORed in
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         tx_valid <= 1'b0;
         tx_word <= 9'h000;
      end
      else
      begin
         tx_valid <= rx_valid;
         if (rx_valid)
            tx_word <= {rx_word[8] | (embed_slot & fault_state), rx_word[7:0]};
      end
   end

   // Base device keeps the result of the last completed vote
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || !chain_control_q[`DCFS_CTL_BASE])
         chain_alert_q <= 1'b0;
      else if (rx_valid && embed_slot && cur_idx == `DCFS_BYTE_REGLO)
         chain_alert_q <= vote_ev;
   end

   // Tone receiver; the pin crosses in through three flops
   logic [2:0] tone_sync_q;
   logic tone_lvl_q;
   logic tone_edge;
   logic [4:0] rx_cnt_q;
   logic [7:0] idle_q;
   logic [19:0] miss_q;
   logic hb_seen;
   logic ft_seen;
   logic hb_miss;
   dcfs_pkg::dcfs_rx_state_type rx_state_q;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         tone_sync_q <= 3'h0;
         tone_lvl_q <= 1'b0;
      end
      else
      begin
         tone_sync_q <= {tone_sync_q[1:0], tone_rx_neg};
         if (tone_sync_q[1] == tone_sync_q[2])
            tone_lvl_q <= tone_sync_q[2];
      end
   end

   assign tone_edge = tone_sync_q[1] && tone_sync_q[2] && !tone_lvl_q;
   assign hb_seen = rx_state_q == dcfs_pkg::RX_BURST && idle_q == 8'(`DCFS_BURST_GAP_CYC)
                    && rx_cnt_q >= 5'(`DCFS_HB_DETECT) && rx_cnt_q < 5'(`DCFS_FT_DETECT);
   assign ft_seen = rx_state_q == dcfs_pkg::RX_BURST && idle_q == 8'(`DCFS_BURST_GAP_CYC)
                    && rx_cnt_q >= 5'(`DCFS_FT_DETECT);
   assign hb_miss = sleep_m && miss_q == 20'(HB_MISS_CYCLES - 1);

   // Receiver runs whenever asleep, whatever the transmit enables say
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || !sleep_m)
      begin
         rx_state_q <= dcfs_pkg::RX_IDLE;
         rx_cnt_q <= 5'h00;
         idle_q <= 8'h00;
      end
      else
      begin
         unique case (rx_state_q)
            dcfs_pkg::RX_IDLE:
               if (tone_edge)
               begin
                  rx_state_q <= dcfs_pkg::RX_BURST;
                  rx_cnt_q <= 5'h01;
                  idle_q <= 8'h00;
               end
            dcfs_pkg::RX_BURST:
               if (tone_edge)
               begin
                  idle_q <= 8'h00;
                  if (rx_cnt_q != 5'h1f)
                     rx_cnt_q <= rx_cnt_q + 5'h01;
               end
               else if (idle_q == 8'(`DCFS_BURST_GAP_CYC))
                  rx_state_q <= dcfs_pkg::RX_IDLE;
               else
                  idle_q <= idle_q + 8'h01;
         endcase
      end
   end

   // A missing heartbeat over several burst periods counts as a heartbeat fault
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b || !sleep_m || hb_seen || ft_seen || hb_miss)
         miss_q <= 20'h0_0000;
      else
         miss_q <= miss_q + 20'h0_0001;
   end

   // Fault flags
   // One driver: tone fault, heartbeat missing and chain fault seen sit above the groups
   assign cond = {ft_seen, hb_miss, vote_ev, fault_cond & gate};

   genvar gi;
   generate
      for (gi = 0; gi < 11; gi++)
      begin : g_flag
         always_ff @(posedge clk_sys)
         begin
            if (!rst_b)
               flag_q[gi] <= 1'b0;
            else if (cond[gi])
               flag_q[gi] <= 1'b1;
            else if (rst_req[gi])
               flag_q[gi] <= 1'b0;
         end
      end
   endgenerate

   // Masks hide a group from the summary but never stop its flag latching
   always_comb
   begin
      summary = flag_q[7:0] & ~mask_q[7:0];
      summary[`DCFS_GRP_COMM] = (flag_q[`DCFS_GRP_COMM] & ~mask_q[`DCFS_GRP_COMM])
                                | |(flag_q[10:8] & ~mask_q[10:8]);
   end

   assign fault_state = |summary;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
         fault_alert_n <= 1'b1;
      else
         fault_alert_n <= !(device_config_q[`DCFS_CFG_ALERT_EN] && (fault_state || chain_alert_q));
   end

   // Tone transmitter
   logic couplet_neg;

   dcfs_tone_tx #(
      .BURST_CYCLES(BURST_CYCLES)
   ) u_tone_tx (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sleep_mode(sleep_m),
      .hb_enable(device_config_q[`DCFS_CFG_HEARTBEAT_TX_ENABLE]),
      .ft_enable(device_config_q[`DCFS_CFG_FT_EN]),
      .fault_state(fault_state),
      .couplet_neg(couplet_neg)
   );

   assign couplet_neg_up = couplet_neg && !chain_control_q[`DCFS_CTL_DIR];
   assign couplet_neg_down = couplet_neg && chain_control_q[`DCFS_CTL_DIR];

   // Checks
   alert_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !device_config_q[`DCFS_CFG_ALERT_EN] |=> fault_alert_n)
      else $error("alert pin low while disabled");

   alert_on_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      device_config_q[`DCFS_CFG_ALERT_EN] && fault_state |=> !fault_alert_n)
      else $error("alert pin not raised for summary");

   embed_or_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rx_valid && embed_slot && fault_state |=> tx_valid && tx_word[8])
      else $error("fault status not ORed into slot");

   embed_pass_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rx_valid && !embed_slot |=> tx_word == $past(rx_word))
      else $error("non-slot byte altered");

   vote_alert_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      vote_ev && chain_control_q[`DCFS_CTL_BASE] && device_config_q[`DCFS_CFG_ALERT_EN]
      ##1 device_config_q[`DCFS_CFG_ALERT_EN] |=> !fault_alert_n)
      else $error("vote did not raise alert");

   vote_seen_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      vote_ev |=> flag_q[`DCFS_CHAIN_SEEN])
      else $error("chain fault seen flag not set");

   sleep_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      sleep_m && !ovuv_prot_en && !flag_q[`DCFS_GRP_OVUV] |=> !flag_q[`DCFS_GRP_OVUV])
      else $error("cell protector flag set while gated");

   tone_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      mask_q[`DCFS_HB_FAULT] && mask_q[`DCFS_TONE_FAULT] && !flag_q[`DCFS_GRP_COMM]
      && !(flag_q[`DCFS_CHAIN_SEEN] && !mask_q[`DCFS_CHAIN_SEEN]) |-> !summary[`DCFS_GRP_COMM])
      else $error("masked tone fault reached summary");

   group_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (mask_q[7:0] & cond[7:0]) != 8'h00
      |=> (flag_q[7:0] & $past(mask_q[7:0] & cond[7:0])) == $past(mask_q[7:0] & cond[7:0])
      && (summary & mask_q[7:0] & 8'hef) == 8'h00)
      else $error("masked group flag or summary wrong");

   reset_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (rst_req[7:0] & cond[7:0]) != 8'h00
      |=> (flag_q[7:0] & $past(rst_req[7:0] & cond[7:0])) == $past(rst_req[7:0] & cond[7:0]))
      else $error("flag cleared while condition persists");

   tone_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !sleep_m ##1 !sleep_m |-> !couplet_neg_up && !couplet_neg_down)
      else $error("tone sent while active");

endmodule

`default_nettype wire

// ---- tb/dcfs_peer.sv ----
// Neighbouring chain device model: response frames and returning ring tones
`timescale 1ns/1ps
`default_nettype none
`include "dcfs_regs.svh"
module dcfs_peer (
   // Clock
   input wire logic clk_sys,
   // Response frame toward the block
   output logic rx_valid,
   output logic rx_first,
   output logic [8:0] rx_word,
   // Tone arriving round the ring
   output logic tone_rx_neg
);
   initial
   begin
      rx_valid = 1'b0;
      rx_first = 1'b0;
      rx_word = 9'h155;
      tone_rx_neg = 1'b0;
   end
   // Response bytes pass through every device on their way down
   task automatic frame(input logic [2:0] st, input logic [31:0] d, input logic slow);
      logic [3:0] sb;
      sb = {st, 1'b1};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_sys);
         rx_valid <= 1'b1;
         rx_first <= (i == 0);
         rx_word <= {sb[i], d[8*i +: 8]};
         if (slow)
         begin
            @(posedge clk_sys);
            rx_valid <= 1'b0;
            rx_word <= ~rx_word;
         end
      end
      @(posedge clk_sys);
      rx_valid <= 1'b0;
      rx_first <= 1'b0;
      // Released lane carries the inverse, so a stale byte can never pass
      rx_word <= ~rx_word;
   endtask
   // Ring returns a burst of negative couplets
   task automatic tone(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         tone_rx_neg <= 1'b1;
         repeat (`DCFS_COUPLET_HALF_CYC) @(posedge clk_sys);
         tone_rx_neg <= 1'b0;
         repeat (`DCFS_COUPLET_HALF_CYC - 1) @(posedge clk_sys);
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the fault signalling block
`timescale 1ns/1ps
`default_nettype none
`include "dcfs_regs.svh"
module testbench;
   localparam int BURST = 800;
   localparam int HB_MISS = 2500;
   logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, ovuv_prot_en, otut_prot_en;
   logic rx_valid, rx_first, tx_valid, tone_rx_neg, couplet_neg_up, couplet_neg_down, fault_alert_n;
   logic [7:0] paddr, fault_cond;
   logic [8:0] rx_word, tx_word;
   logic [31:0] pwdata, prdata, r, ef, em, cfg;
   logic [31:0] lfsr_q = 32'h0000_ee30;
   logic e, ca;
   logic up_q = 1'b0;
   logic dn_q = 1'b0;
   logic [3:0] tc;
   logic [8:0] txq [$];
   int fails, num_checks, g, nc, a0, a1;
   int cnt_up = 0;
   int cnt_dn = 0;

   dcfs_core #(.BURST_CYCLES(BURST), .HB_MISS_CYCLES(HB_MISS)) u_dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fault_cond(fault_cond), .ovuv_prot_en(ovuv_prot_en), .otut_prot_en(otut_prot_en),
      .rx_valid(rx_valid), .rx_first(rx_first), .rx_word(rx_word), .tx_valid(tx_valid),
      .tx_word(tx_word), .tone_rx_neg(tone_rx_neg), .couplet_neg_up(couplet_neg_up),
      .couplet_neg_down(couplet_neg_down), .fault_alert_n(fault_alert_n));
   dcfs_peer u_peer (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_first(rx_first),
      .rx_word(rx_word), .tone_rx_neg(tone_rx_neg));

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      up_q <= couplet_neg_up;
      dn_q <= couplet_neg_down;
      cnt_up <= cnt_up + int'(couplet_neg_up === 1'b1 && up_q !== 1'b1);
      cnt_dn <= cnt_dn + int'(couplet_neg_down === 1'b1 && dn_q !== 1'b1);
   end
   always @(negedge clk_sys)
      if (tx_valid === 1'b1)
         txq.push_back(tx_word);

   function logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q;
   endfunction
   // Summary as software should see it
   function automatic logic [31:0] summ();
      logic [31:0] s;
      s = ef & ~em;
      return (s & 32'h0000_00ff) | {27'h0, |s[10:8], 4'h0};
   endfunction
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // Waits as long as the slave asks; only the watchdog ends a hung access
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk("pslverr", 32'h0, {31'h0, e});
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, r);
      chk("pslverr", 32'h0, {31'h0, e});
   endtask
   task automatic cond(input logic [7:0] v);
      @(posedge clk_sys);
      fault_cond <= v;
   endtask
   task automatic look();
      repeat (4) @(negedge clk_sys);
      chk("fault_alert_n", {31'h0, !(cfg[0] && (summ() != 32'h0 || ca))}, {31'h0, fault_alert_n});
      rd("flags", `DCFS_OFF_FAULT_FLAGS, ef);
      rd("summary", `DCFS_OFF_FAULT_SUMMARY, summ());
   endtask
   task automatic send(input logic [2:0] st);
      logic [31:0] d;
      logic [3:0] sb;
      d = rnd();
      sb = {st | {3{cfg[1] && summ() != 32'h0}}, 1'b1};
      u_peer.frame(st, d, d[31]);
      repeat (3) @(negedge clk_sys);
      chk("tx_count", 32'h4, 32'(txq.size()));
      for (int i = 0; i < 4 && txq.size() > 0; i++)
         chk("tx_word", {23'h0, sb[i], d[8*i +: 8]}, {23'h0, txq.pop_front()});
   endtask
   task automatic test_done();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Whole run is near 13000 cycles; over four times that means a hang
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      fails++;
      test_done();
   end

   initial
   begin
      rst_b = 1'b0;
      {psel, penable, pwrite, ovuv_prot_en, otut_prot_en, ca} = 6'h0;
      {paddr, fault_cond, pwdata, ef, em, cfg} = 144'h0;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int a = 0; a < 24; a += 4)
         rd("reset value", 8'(a), 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk("pslverr", 32'h1, {31'h0, e});
      g = int'(rnd() % 32'h8);
      cond(8'h01 << g);
      ef = 32'h1 << g;
      look();
      cfg = 32'h1;
      wr(`DCFS_OFF_DEVICE_CONFIG, cfg);
      look();
      em = ef;
      wr(`DCFS_OFF_FAULT_MASK, em);
      look();
      wr(`DCFS_OFF_FAULT_RESET, ef);
      look();
      cond(8'h00);
      wr(`DCFS_OFF_FAULT_RESET, ef);
      ef = 32'h0;
      look();
      em = 32'h0;
      wr(`DCFS_OFF_FAULT_MASK, em);
      cfg = 32'h3;
      wr(`DCFS_OFF_DEVICE_CONFIG, cfg);
      send(3'b001);
      cond(8'h01);
      ef = 32'h1;
      look();
      send(3'b000);
      cfg = 32'h1;
      wr(`DCFS_OFF_DEVICE_CONFIG, cfg);
      send(3'b010);
      cond(8'h00);
      wr(`DCFS_OFF_FAULT_RESET, ef);
      ef = 32'h0;
      cfg = 32'h3;
      wr(`DCFS_OFF_DEVICE_CONFIG, cfg);
      wr(`DCFS_OFF_CHAIN_CONTROL, 32'h4);
      for (int p = 0; p < 8; p++)
      begin
         send(3'(p));
         ca = ($countones(3'(p)) >= 2);
         if (ca)
            ef = ef | 32'h0000_0100;
         look();
      end
      em = 32'h0000_0100;
      wr(`DCFS_OFF_FAULT_MASK, em);
      wr(`DCFS_OFF_FAULT_RESET, ef);
      send(3'b111);
      look();
      send(3'b000);
      ca = 1'b0;
      look();
      wr(`DCFS_OFF_FAULT_RESET, ef);
      ef = 32'h0;
      em = 32'h0000_0600;
      wr(`DCFS_OFF_FAULT_MASK, em);
      for (int k = 0; k < 5; k++)
      begin
         tc = 4'(20'h2_d3c4 >> (4 * k));
         cond({7'h0, tc[0]});
         wr(`DCFS_OFF_FAULT_RESET, 32'h0000_07ff);
         cfg = {28'h0, tc[1], tc[2], 2'h1};
         wr(`DCFS_OFF_DEVICE_CONFIG, cfg);
         wr(`DCFS_OFF_CHAIN_CONTROL, {29'h0, 2'h1, tc[3]});
         nc = (tc[0] && tc[1]) ? `DCFS_FT_COUPLETS : (!tc[0] && tc[2]) ? `DCFS_HB_COUPLETS : 0;
         repeat (900) @(negedge clk_sys);
         a0 = cnt_up;
         a1 = cnt_dn;
         repeat (BURST) @(negedge clk_sys);
         chk("up couplets", tc[3] ? 0 : nc, cnt_up - a0);
         chk("down couplets", tc[3] ? nc : 0, cnt_dn - a1);
      end
      wr(`DCFS_OFF_CHAIN_CONTROL, 32'h0);
      cond(8'h00);
      wr(`DCFS_OFF_FAULT_RESET, 32'h0000_07ff);
      cfg = 32'h1;
      wr(`DCFS_OFF_DEVICE_CONFIG, cfg);
      wr(`DCFS_OFF_CHAIN_CONTROL, 32'h2);
      u_peer.tone(`DCFS_HB_COUPLETS);
      repeat (100) @(posedge clk_sys);
      look();
      u_peer.tone(`DCFS_FT_COUPLETS);
      repeat (100) @(posedge clk_sys);
      ef = 32'h0000_0400;
      look();
      em = 32'h0;
      wr(`DCFS_OFF_FAULT_MASK, em);
      look();
      repeat (HB_MISS + 100) @(posedge clk_sys);
      ef = 32'h0000_0600;
      look();
      wr(`DCFS_OFF_CHAIN_CONTROL, 32'h0);
      wr(`DCFS_OFF_FAULT_RESET, 32'h0000_07ff);
      wr(`DCFS_OFF_CHAIN_CONTROL, 32'h2);
      @(posedge clk_sys);
      fault_cond <= 8'hff;
      otut_prot_en <= 1'b1;
      ef = 32'h0000_002b;
      look();
      @(posedge clk_sys);
      ovuv_prot_en <= 1'b1;
      ef = 32'h0000_002f;
      look();
      test_done();
   end
endmodule
`default_nettype wire
